// ==== include/adc_cfg_pkg.sv ====
// constants of the converter configuration port: word layout, register map, pin codes, timing
package adc_cfg_pkg;

    // serial word: address first, then data, most significant bit first
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 11;
    localparam int REG_COUNT = 32;
    localparam logic [3:0] LAST_BIT = 4'hf;

    // register addresses
    localparam logic [4:0] ADDR_PWR_REF = 5'h00;
    localparam logic [4:0] ADDR_PATTERN = 5'h0a;
    localparam logic [4:0] ADDR_IFACE = 5'h0d;

    // value after any reset
    localparam logic [10:0] REG_DEFAULT = 11'h000;

    // field positions in the power and reference register
    localparam int POS_SW_RESET = 10;
    localparam int POS_REF_INTERNAL = 5;
    localparam int POS_PDN_GLOBAL = 0;

    // field positions in the pattern register
    localparam int POS_OFFSET_BIN = 9;
    localparam int POS_PAT_HI = 7;
    localparam int POS_PAT_LO = 5;

    // field positions in the interface register
    localparam int POS_OVERRIDE = 10;
    localparam int POS_LSB_FIRST = 6;
    localparam int POS_COARSE_GAIN = 5;
    localparam int POS_CAPTURE_RISE = 4;
    localparam int POS_SER_16X = 3;
    localparam int POS_SDR = 2;
    localparam int POS_TWO_WIRE = 1;

    // test pattern codes
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_SYNC = 3'h1;
    localparam logic [2:0] PAT_DESKEW = 3'h2;

    // four-level pin codes: ground, 3/8 supply, 5/8 supply, supply
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_SUPPLY = 2'h3;

    // timing
    localparam int SYS_CLK_NS = 40;
    localparam int WRITE_EFFECT_NS = 100;
    localparam int WRITE_EFFECT_CYCLES = (WRITE_EFFECT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

endpackage

// ==== hw/adc_config_serial_port.sv ====
// serial configuration port, register file and pin/register arbitration of the converter
// Function
// - shift only while select is held low
// - sample data on falling shift-clock edges
// - every 16th edge writes addressed register
// - partial trailing word is discarded
// - several words per select low period
// - five address bits, then eleven data bits
// - write takes effect shortly after 16th edge
// - reset pin pulse restores register defaults
// - software reset bit clears registers, self-clears
// - override bit picks registers over config pins
// - power-down pin forces global power down
// - serial coarse gain needs override, else 0 dB
// - serial reference, pattern, power from registers
// - parallel clock/data pair selects pattern, power
// - parallel select level picks reference and gain
// - pin one picks bit clock and wires
// - pin two picks serialization and edge
// - pin four picks bit order and format
// - power-up configuration follows pin levels
`timescale 1ns/1ps

module adc_config_serial_port (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic serial_clk,
    input wire logic serial_select_low,
    input wire logic serial_in_line,
    input wire logic reset_pin,
    input wire logic parallel_mode,
    input wire logic pdn_pin,
    input wire logic [1:0] select_level,
    input wire logic [1:0] config_pin_one,
    input wire logic [1:0] config_pin_two,
    input wire logic [1:0] config_pin_four,
    output logic global_power_down,
    output logic ref_internal,
    output logic coarse_gain_high,
    output logic [2:0] test_pattern,
    output logic two_wire,
    output logic sdr_bit_clock,
    output logic serial_16x,
    output logic capture_rising,
    output logic lsb_first,
    output logic offset_binary,
    output logic cfg_unused_level,
    output logic write_done,
    output logic [4:0] write_addr
);

    localparam int PIN_COUNT = 12;
    localparam int EFFECT_MAX = 2 * adc_cfg_pkg::WRITE_EFFECT_CYCLES;

    // ---------------- link domain: shift register on the serial clock
    logic link_clr;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [14:0] shift;
    logic [14:0] next_shift;
    logic [15:0] word_hold;
    logic [15:0] next_word_hold;
    logic word_tgl;
    logic next_word_tgl;

    // select high ends the frame and drops any partial word
    assign link_clr = serial_select_low | ~rstn;

    always_comb begin
        next_bit_cnt = bit_cnt + 4'h1;
        next_shift = {shift[13:0], serial_in_line};
        next_word_hold = word_hold;
        next_word_tgl = word_tgl;
        if (bit_cnt == adc_cfg_pkg::LAST_BIT) begin
            next_word_hold = {shift, serial_in_line};
            next_word_tgl = ~word_tgl;
        end
    end

    always_ff @(negedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= 4'h0;
            shift <= 15'h0000;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
        end
    end

    // the finished word outlives the frame, so only the system reset clears it
    always_ff @(negedge serial_clk or negedge rstn) begin
        if (!rstn) begin
            word_hold <= 16'h0000;
            word_tgl <= 1'b0;
        end else if (!serial_select_low) begin
            word_hold <= next_word_hold;
            word_tgl <= next_word_tgl;
        end
    end

    // ---------------- crossing of the word event into the system domain
    logic [2:0] tgl_sync;
    logic word_evt;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tgl_sync <= 3'h0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], word_tgl};
        end
    end

    assign word_evt = tgl_sync[2] ^ tgl_sync[1];

    // ---------------- reset pin: a pulse shorter than a clock is caught asynchronously
    logic rp_catch;
    logic [2:0] rp_sync;
    logic hw_reset;

    always_ff @(posedge clk_sys or posedge reset_pin or negedge rstn) begin
        if (!rstn) begin
            rp_catch <= 1'b0;
        end else if (reset_pin) begin
            rp_catch <= 1'b1;
        end else begin
            rp_catch <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rp_sync <= 3'h0;
        end else begin
            rp_sync <= {rp_sync[1:0], rp_catch};
        end
    end

    assign hw_reset = rp_sync[1] | rp_sync[2];

    // ---------------- static pins: three flops, a change counts when stages two and three agree
    logic [PIN_COUNT-1:0] pin_vec;
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic [PIN_COUNT-1:0] pin_s3;
    logic [PIN_COUNT-1:0] pin_f;

    assign pin_vec = {parallel_mode, pdn_pin, serial_clk, serial_in_line,
                      select_level, config_pin_one, config_pin_two, config_pin_four};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            logic next_f;
            always_comb begin
                next_f = pin_f[gi];
                if (pin_s2[gi] == pin_s3[gi]) begin
                    next_f = pin_s3[gi];
                end
            end
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_f[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_vec[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    pin_f[gi] <= next_f;
                end
            end
        end
    endgenerate

    logic par_f;
    logic pdn_f;
    logic sclk_f;
    logic data_lvl_f;
    logic [1:0] sel_lvl_f;
    logic [1:0] pin_one_f;
    logic [1:0] pin_two_f;
    logic [1:0] pin_four_f;

    assign {par_f, pdn_f, sclk_f, data_lvl_f, sel_lvl_f, pin_one_f, pin_two_f, pin_four_f} = pin_f;

    // ---------------- register file
    logic [10:0] regs [adc_cfg_pkg::REG_COUNT];
    logic [10:0] next_regs [adc_cfg_pkg::REG_COUNT];
    logic next_write_done;
    logic [4:0] next_write_addr;
    logic [4:0] w_addr;
    logic [10:0] w_data;

    assign w_addr = word_hold[15:11];
    assign w_data = word_hold[10:0];

    always_comb begin
        next_regs = regs;
        next_write_done = 1'b0;
        next_write_addr = write_addr;
        if (hw_reset) begin
            for (int i = 0; i < adc_cfg_pkg::REG_COUNT; i++) begin
                next_regs[i] = adc_cfg_pkg::REG_DEFAULT;
            end
        end else if (word_evt) begin
            next_write_done = 1'b1;
            next_write_addr = w_addr;
            if (w_addr == adc_cfg_pkg::ADDR_PWR_REF && w_data[adc_cfg_pkg::POS_SW_RESET]) begin
                // the reset bit itself is never stored, so it reads back as zero
                for (int i = 0; i < adc_cfg_pkg::REG_COUNT; i++) begin
                    next_regs[i] = adc_cfg_pkg::REG_DEFAULT;
                end
            end else begin
                next_regs[w_addr] = w_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < adc_cfg_pkg::REG_COUNT; i++) begin
                regs[i] <= adc_cfg_pkg::REG_DEFAULT;
            end
            write_done <= 1'b0;
            write_addr <= 5'h00;
        end else begin
            regs <= next_regs;
            write_done <= next_write_done;
            write_addr <= next_write_addr;
        end
    end

    // ---------------- arbitration between pins and registers
    logic [10:0] r_pwr;
    logic [10:0] r_pat;
    logic [10:0] r_if;
    logic ovrd;

    assign r_pwr = regs[adc_cfg_pkg::ADDR_PWR_REF];
    assign r_pat = regs[adc_cfg_pkg::ADDR_PATTERN];
    assign r_if = regs[adc_cfg_pkg::ADDR_IFACE];
    assign ovrd = r_if[adc_cfg_pkg::POS_OVERRIDE];

    logic next_pdn;
    logic next_ref;
    logic next_gain;
    logic [2:0] next_pat;
    logic next_two;
    logic next_sdr;
    logic next_16x;
    logic next_rise;
    logic next_lsb;
    logic next_ob;
    logic next_unused;

    always_comb begin
        next_unused = 1'b0;
        if (par_f) begin
            next_pdn = pdn_f | (sclk_f & ~data_lvl_f);
            unique case ({sclk_f, data_lvl_f})
                2'b01: next_pat = adc_cfg_pkg::PAT_SYNC;
                2'b11: next_pat = adc_cfg_pkg::PAT_DESKEW;
                2'b00, 2'b10: next_pat = adc_cfg_pkg::PAT_NORMAL;
            endcase
            next_ref = sel_lvl_f[1];
            next_gain = sel_lvl_f[0] ^ sel_lvl_f[1];
        end else begin
            next_pdn = pdn_f | r_pwr[adc_cfg_pkg::POS_PDN_GLOBAL];
            next_pat = r_pat[adc_cfg_pkg::POS_PAT_HI:adc_cfg_pkg::POS_PAT_LO];
            next_ref = r_pwr[adc_cfg_pkg::POS_REF_INTERNAL];
            next_gain = ovrd & r_if[adc_cfg_pkg::POS_COARSE_GAIN];
        end
        if (ovrd) begin
            next_two = r_if[adc_cfg_pkg::POS_TWO_WIRE];
            next_sdr = r_if[adc_cfg_pkg::POS_SDR];
            next_16x = r_if[adc_cfg_pkg::POS_SER_16X];
            next_rise = r_if[adc_cfg_pkg::POS_CAPTURE_RISE];
            next_lsb = r_if[adc_cfg_pkg::POS_LSB_FIRST];
            next_ob = r_pat[adc_cfg_pkg::POS_OFFSET_BIN];
        end else begin
            // defaults leave the override clear, so power-up follows the pins
            next_unused = (pin_one_f == adc_cfg_pkg::LVL_LOW);
            next_two = (pin_one_f != adc_cfg_pkg::LVL_GND) && !next_unused;
            next_sdr = (pin_one_f == adc_cfg_pkg::LVL_HIGH);
            next_16x = pin_two_f[0] ^ pin_two_f[1];
            next_rise = pin_two_f[1];
            next_lsb = pin_four_f[1];
            next_ob = pin_four_f[0] ^ pin_four_f[1];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            global_power_down <= 1'b0;
            ref_internal <= 1'b0;
            coarse_gain_high <= 1'b0;
            test_pattern <= adc_cfg_pkg::PAT_NORMAL;
            two_wire <= 1'b0;
            sdr_bit_clock <= 1'b0;
            serial_16x <= 1'b0;
            capture_rising <= 1'b0;
            lsb_first <= 1'b0;
            offset_binary <= 1'b0;
            cfg_unused_level <= 1'b0;
        end else begin
            global_power_down <= next_pdn;
            ref_internal <= next_ref;
            coarse_gain_high <= next_gain;
            test_pattern <= next_pat;
            two_wire <= next_two;
            sdr_bit_clock <= next_sdr;
            serial_16x <= next_16x;
            capture_rising <= next_rise;
            lsb_first <= next_lsb;
            offset_binary <= next_ob;
            cfg_unused_level <= next_unused;
        end
    end

    // ---------------- assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    word_capture_a: assert property (@(negedge serial_clk) disable iff (link_clr)
        (bit_cnt == adc_cfg_pkg::LAST_BIT) |=>
        (word_hold == {$past(shift), $past(serial_in_line)}) && (word_tgl != $past(word_tgl)))
        else $error("completed word not captured");

    partial_word_a: assert property (@(negedge serial_clk) disable iff (link_clr)
        (bit_cnt != adc_cfg_pkg::LAST_BIT) |=> $stable(word_tgl))
        else $error("word event before sixteen bits");

    write_effect_a: assert property (
        disable iff (!rstn || hw_reset) $changed(word_tgl) |-> ##[1:EFFECT_MAX] write_done)
        else $error("register write not effective in time");

    reg_store_a: assert property (
        word_evt && !hw_reset && (w_addr != adc_cfg_pkg::ADDR_PWR_REF) |=>
        regs[$past(w_addr)] == $past(w_data) ##1 !write_done)
        else $error("addressed register not written");

    sw_reset_a: assert property (
        word_evt && (w_addr == adc_cfg_pkg::ADDR_PWR_REF) && w_data[adc_cfg_pkg::POS_SW_RESET] |=>
        (regs[adc_cfg_pkg::ADDR_PWR_REF] == adc_cfg_pkg::REG_DEFAULT)
        && (regs[adc_cfg_pkg::ADDR_IFACE] == adc_cfg_pkg::REG_DEFAULT))
        else $error("software reset left a register set");

    hw_reset_a: assert property (
        hw_reset |=> (regs[adc_cfg_pkg::ADDR_IFACE] == adc_cfg_pkg::REG_DEFAULT) && !write_done)
        else $error("reset pin did not restore defaults");

    pdn_force_a: assert property (pdn_f |=> global_power_down)
        else $error("power-down pin ignored");

    gain_gate_a: assert property (!par_f && !ovrd |=> !coarse_gain_high)
        else $error("coarse gain without override");

    override_a: assert property (
        ovrd |=> (two_wire == $past(r_if[adc_cfg_pkg::POS_TWO_WIRE]))
        && (lsb_first == $past(r_if[adc_cfg_pkg::POS_LSB_FIRST])))
        else $error("override did not select registers");

    cfg_one_a: assert property (
        !ovrd && (pin_one_f == adc_cfg_pkg::LVL_HIGH) |=> sdr_bit_clock && two_wire)
        else $error("pin one decode wrong");

    cfg_four_a: assert property (
        !ovrd && (pin_four_f == adc_cfg_pkg::LVL_LOW) |=> !lsb_first && offset_binary)
        else $error("pin four decode wrong");

    par_pair_a: assert property (
        par_f && sclk_f && data_lvl_f |=> test_pattern == adc_cfg_pkg::PAT_DESKEW)
        else $error("parallel deskew decode wrong");

    sel_level_a: assert property (
        par_f && (sel_lvl_f == adc_cfg_pkg::LVL_LOW) |=> !ref_internal && coarse_gain_high)
        else $error("parallel select level decode wrong");

    word_write_c: cover property (word_evt ##[1:40] word_evt);
    sw_reset_c: cover property (word_evt && w_data[adc_cfg_pkg::POS_SW_RESET]);
    pdn_pin_c: cover property (!par_f && pdn_f ##1 global_power_down);
    override_c: cover property ($rose(ovrd));

endmodule

// ==== bench/serial_host_model.sv ====
// host controller model driving the serial configuration port and the reset pin
`timescale 1ns/1ps

module serial_host_model (
    output logic serial_clk,
    output logic serial_select_low,
    output logic serial_in_line,
    output logic reset_pin
);
    logic [15:0] word_q[$];

    // shift clock idles high; outside frames only stray_clocks and set_levels move it
    initial begin
        serial_clk = 1'b1;
        serial_select_low = 1'b1;
        serial_in_line = 1'b0;
        reset_pin = 1'b0;
    end

    // data changes while the clock is high and is taken on the falling edge
    task automatic shift_bit(input logic b);
        serial_in_line = b;
        #3 serial_clk = 1'b0;
        #3 serial_clk = 1'b1;
    endtask

    // queued words in one select low period, then the first tail_bits of tail
    task automatic frame(input int tail_bits, input logic [15:0] tail);
        serial_select_low = 1'b0;
        #25;
        foreach (word_q[w]) begin
            for (int i = 15; i >= 0; i--) shift_bit(word_q[w][i]);
            // spaces the word ends apart so each crossing completes
            #400;
        end
        for (int i = 15; i > 15 - tail_bits; i--) shift_bit(tail[i]);
        #25 serial_select_low = 1'b1;
        serial_in_line = ~serial_in_line;
        word_q.delete();
    endtask

    // clock edges with select high must be ignored by the device
    task automatic stray_clocks(input int n);
        for (int i = 0; i < n; i++) shift_bit(~serial_in_line);
    endtask

    // reset pulse, then the wait before the first select
    task automatic pulse_reset(input int width);
        reset_pin = 1'b1;
        #(width) reset_pin = 1'b0;
        #200;
    endtask

    // shift clock and data lines used as level pins in parallel mode
    task automatic set_levels(input logic c, input logic d);
        serial_clk = c;
        serial_in_line = d;
    endtask
endmodule

// ==== bench/test_adc_config_serial_port.sv ====
// self-checking testbench of the converter configuration port
`timescale 1ns/1ps

module test_adc_config_serial_port;
    logic clk_sys, rstn, parallel_mode, pdn_pin;
    logic serial_clk, serial_select_low, serial_in_line, reset_pin;
    logic [1:0] select_level, config_pin_one, config_pin_two, config_pin_four;
    logic global_power_down, ref_internal, coarse_gain_high, two_wire, sdr_bit_clock;
    logic serial_16x, capture_rising, lsb_first, offset_binary, cfg_unused_level, write_done;
    logic [2:0] test_pattern;
    logic [4:0] write_addr;
    int err_count = 0;
    int num_checks = 0;
    int done_cnt = 0;
    int exp_done = 0;

    adc_config_serial_port i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .serial_clk(serial_clk),
        .serial_select_low(serial_select_low), .serial_in_line(serial_in_line),
        .reset_pin(reset_pin), .parallel_mode(parallel_mode), .pdn_pin(pdn_pin),
        .select_level(select_level), .config_pin_one(config_pin_one),
        .config_pin_two(config_pin_two), .config_pin_four(config_pin_four),
        .global_power_down(global_power_down), .ref_internal(ref_internal),
        .coarse_gain_high(coarse_gain_high), .test_pattern(test_pattern),
        .two_wire(two_wire), .sdr_bit_clock(sdr_bit_clock), .serial_16x(serial_16x),
        .capture_rising(capture_rising), .lsb_first(lsb_first),
        .offset_binary(offset_binary), .cfg_unused_level(cfg_unused_level),
        .write_done(write_done), .write_addr(write_addr)
    );

    serial_host_model i_host (
        .serial_clk(serial_clk), .serial_select_low(serial_select_low),
        .serial_in_line(serial_in_line), .reset_pin(reset_pin)
    );

    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (write_done === 1'b1) done_cnt <= done_cnt + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // waits a bounded time for the expected number of accepted words
    task automatic settle(input int add);
        int n;
        n = 0;
        exp_done += add;
        while (done_cnt != exp_done && n < 6) begin
            @(posedge clk_sys);
            n++;
        end
        tick(3);
        chk(16'(done_cnt), 16'(exp_done));
    endtask

    task automatic set_pins(input logic [1:0] lv);
        select_level = lv;
        config_pin_one = lv;
        config_pin_two = lv;
        config_pin_four = lv;
    endtask

    initial begin
        #300000;
        err_count++;
        conclude();
    end

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        parallel_mode = 1'b1;
        pdn_pin = 1'b0;
        set_pins(adc_cfg_pkg::LVL_SUPPLY);
        repeat (12) @(posedge clk_sys);
        #1 rstn = 1'b1;
        tick(8);
        chk(lsb_first, 1'b1);
        chk(ref_internal, 1'b1);
        chk(global_power_down, 1'b1);
        for (int i = 0; i < 4; i++) begin
            set_pins(2'(i));
            i_host.set_levels(i[1], i[0]);
            tick(8);
            chk(ref_internal, 4'b1100 >> i & 1);
            chk(coarse_gain_high, 4'b0110 >> i & 1);
            chk(global_power_down, 4'b0100 >> i & 1);
            if (i != 2) chk(test_pattern, i == 1 ? adc_cfg_pkg::PAT_SYNC :
                i == 3 ? adc_cfg_pkg::PAT_DESKEW : adc_cfg_pkg::PAT_NORMAL);
            chk(two_wire, 4'b1100 >> i & 1);
            chk(sdr_bit_clock, 4'b0100 >> i & 1);
            chk(cfg_unused_level, 4'b0010 >> i & 1);
            chk(serial_16x, 4'b0110 >> i & 1);
            chk(capture_rising, 4'b1100 >> i & 1);
            chk(lsb_first, 4'b1100 >> i & 1);
            chk(offset_binary, 4'b0110 >> i & 1);
        end
        // serial mode, pins grounded; the reserved third pin has no port
        parallel_mode = 1'b0;
        set_pins(adc_cfg_pkg::LVL_GND);
        i_host.set_levels(1'b1, 1'b0);
        i_host.pulse_reset(12);
        tick(8);
        chk(ref_internal, 1'b0);
        i_host.word_q.push_back(16'h0021);
        i_host.frame(0, 16'h0000);
        settle(1);
        chk(ref_internal, 1'b1);
        chk(global_power_down, 1'b1);
        chk(write_addr, adc_cfg_pkg::ADDR_PWR_REF);
        i_host.word_q.push_back(16'h6820);
        i_host.word_q.push_back(16'h5220);
        i_host.frame(0, 16'h0000);
        settle(2);
        chk(coarse_gain_high, 1'b0);
        chk(test_pattern, adc_cfg_pkg::PAT_SYNC);
        chk(offset_binary, 1'b0);
        chk(write_addr, adc_cfg_pkg::ADDR_PATTERN);
        i_host.word_q.push_back(16'h6c66);
        i_host.frame(15, 16'h6800);
        settle(1);
        chk(coarse_gain_high, 1'b1);
        chk(lsb_first, 1'b1);
        chk(offset_binary, 1'b1);
        chk(two_wire, 1'b1);
        chk(sdr_bit_clock, 1'b1);
        chk(serial_16x, 1'b0);
        chk(write_addr, adc_cfg_pkg::ADDR_IFACE);
        i_host.stray_clocks(16);
        settle(0);
        chk(lsb_first, 1'b1);
        i_host.word_q.push_back(16'h0400);
        i_host.frame(0, 16'h0000);
        settle(1);
        chk(ref_internal, 1'b0);
        chk(test_pattern, adc_cfg_pkg::PAT_NORMAL);
        chk(coarse_gain_high, 1'b0);
        chk(lsb_first, 1'b0);
        chk(write_addr, adc_cfg_pkg::ADDR_PWR_REF);
        i_host.word_q.push_back(16'h0020);
        i_host.frame(0, 16'h0000);
        settle(1);
        chk(ref_internal, 1'b1);
        chk(global_power_down, 1'b0);
        pdn_pin = 1'b1;
        tick(8);
        chk(global_power_down, 1'b1);
        pdn_pin = 1'b0;
        tick(8);
        chk(global_power_down, 1'b0);
        // override clear: the pins still set the interface in serial mode
        select_level = adc_cfg_pkg::LVL_LOW;
        config_pin_one = adc_cfg_pkg::LVL_HIGH;
        config_pin_two = adc_cfg_pkg::LVL_LOW;
        config_pin_four = adc_cfg_pkg::LVL_SUPPLY;
        tick(8);
        chk(sdr_bit_clock, 1'b1);
        chk(two_wire, 1'b1);
        chk(serial_16x, 1'b1);
        chk(capture_rising, 1'b0);
        chk(lsb_first, 1'b1);
        chk(offset_binary, 1'b0);
        chk(coarse_gain_high, 1'b0);
        chk(ref_internal, 1'b1);
        i_host.pulse_reset(12);
        tick(8);
        chk(ref_internal, 1'b0);
        i_host.word_q.push_back(16'h0020);
        i_host.frame(0, 16'h0000);
        settle(1);
        chk(ref_internal, 1'b1);
        // system reset in mid-run: outputs clear, then follow the pins again
        rstn = 1'b0;
        tick(2);
        chk(sdr_bit_clock, 1'b0);
        rstn = 1'b1;
        tick(8);
        chk(ref_internal, 1'b0);
        chk(sdr_bit_clock, 1'b1);
        chk(lsb_first, 1'b1);
        conclude();
    end
endmodule
